// *** common/brk_pkg.sv ***
package brk_pkg;

    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_ADDRESS_HIGH   = 8'h04;
    localparam logic [7:0] ADDR_ADDRESS_LOW    = 8'h08;
    localparam logic [7:0] ADDR_WAKEUP_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_FLAG_CLEAR     = 8'h10;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BREAK_ENABLE_POS       = 7;
    localparam int BREAK_ACTIVE_POS       = 6;
    localparam int BREAK_WAKEUP_POS       = 1;
    localparam int BREAK_CLEAR_ENABLE_POS = 7;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ----------------------------------------
    // cpu side carriers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] address;
        logic        address_valid;
        logic        last_cycle;
        logic        break_start;
        logic        break_return;
        logic        in_wait;
        logic        in_stop;
    } cpu_status_t;

    typedef struct packed {
        logic break_request;
        logic wake_request;
        logic break_state;
        logic timers_halt;
        logic watchdog_off;
        logic flag_clear_allowed;
    } cpu_control_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_PENDING = 3'b010,
        ST_BREAK   = 3'b100
    } brk_state_t;

endpackage

// *** src/address_breakpoint_unit.sv ***
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps

module address_breakpoint_unit (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RESET_N,
    input  wire logic [7:0]            PADDR,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [31:0]           PWDATA,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire brk_pkg::cpu_status_t  CPU_STATUS,
    input  wire logic                  TEST_VOLTAGE_PIN,
    output brk_pkg::cpu_control_t      CPU_CONTROL
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic                 break_enable_bit;
    logic                 break_active_bit;
    logic                 break_wakeup_flag;
    logic                 break_clear_enable_bit;
    logic [7:0]           break_address_high;
    logic [7:0]           break_address_low;
    brk_pkg::brk_state_t  state;
    logic                 tv_meta;
    logic                 tv_sync;

    logic                 next_break_enable_bit;
    logic                 next_break_active_bit;
    logic                 next_break_wakeup_flag;
    logic                 next_break_clear_enable_bit;
    logic [7:0]           next_break_address_high;
    logic [7:0]           next_break_address_low;
    brk_pkg::brk_state_t  next_state;
    logic [31:0]          next_prdata;
    logic                 next_pready;
    logic                 next_pslverr;
    logic                 next_tv_meta;
    logic                 next_tv_sync;
    brk_pkg::cpu_control_t next_control;

    logic                 wr_en;
    logic                 rd_en;
    logic                 match;
    logic                 soft_break;
    logic                 trigger;
    logic                 sleeping;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == brk_pkg::ADDR_STATUS_CONTROL) || (a == brk_pkg::ADDR_ADDRESS_HIGH)
              || (a == brk_pkg::ADDR_ADDRESS_LOW) || (a == brk_pkg::ADDR_WAKEUP_STATUS)
              || (a == brk_pkg::ADDR_FLAG_CLEAR);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    always_comb begin
        wr_en      = PSEL && PENABLE && PREADY && PWRITE;
        rd_en      = PSEL && !PENABLE && !PWRITE;
        match      = break_enable_bit && CPU_STATUS.address_valid
                     && (CPU_STATUS.address == {break_address_high, break_address_low});
        soft_break = wr_en && hit(PADDR, brk_pkg::ADDR_STATUS_CONTROL)
                     && PWDATA[brk_pkg::BREAK_ACTIVE_POS];
        trigger    = match || soft_break;
        sleeping   = CPU_STATUS.in_wait || CPU_STATUS.in_stop;
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;

        // apb: answer one cycle after setup, write applied in access phase
        if (PSEL && !PENABLE) begin
            next_pready  = 1'b1;
            next_pslverr = !mapped(PADDR);
        end
        if (rd_en) begin
            case (PADDR)
                brk_pkg::ADDR_STATUS_CONTROL: begin
                    next_prdata[brk_pkg::BREAK_ENABLE_POS] = break_enable_bit;
                    next_prdata[brk_pkg::BREAK_ACTIVE_POS] = break_active_bit;
                end
                brk_pkg::ADDR_ADDRESS_HIGH: begin
                    next_prdata[7:0] = break_address_high;
                end
                brk_pkg::ADDR_ADDRESS_LOW: begin
                    next_prdata[7:0] = break_address_low;
                end
                brk_pkg::ADDR_WAKEUP_STATUS: begin
                    next_prdata[brk_pkg::BREAK_WAKEUP_POS] = break_wakeup_flag;
                end
                brk_pkg::ADDR_FLAG_CLEAR: begin
                    next_prdata[brk_pkg::BREAK_CLEAR_ENABLE_POS] = break_clear_enable_bit;
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    always_comb begin
        next_break_enable_bit       = break_enable_bit;
        next_break_active_bit       = break_active_bit;
        next_break_clear_enable_bit = break_clear_enable_bit;
        next_break_address_high     = break_address_high;
        next_break_address_low      = break_address_low;
        if (wr_en) begin
            case (PADDR)
                brk_pkg::ADDR_STATUS_CONTROL: begin
                    next_break_enable_bit = PWDATA[brk_pkg::BREAK_ENABLE_POS];
                    next_break_active_bit = PWDATA[brk_pkg::BREAK_ACTIVE_POS];
                end
                brk_pkg::ADDR_ADDRESS_HIGH: begin
                    next_break_address_high = PWDATA[7:0];
                end
                brk_pkg::ADDR_ADDRESS_LOW: begin
                    next_break_address_low = PWDATA[7:0];
                end
                brk_pkg::ADDR_FLAG_CLEAR: begin
                    next_break_clear_enable_bit = PWDATA[brk_pkg::BREAK_CLEAR_ENABLE_POS];
                end
                default: begin
                    next_break_enable_bit = break_enable_bit;
                end
            endcase
        end

        // hardware set wins over software clear
        if (match) begin
            next_break_active_bit = 1'b1;
        end
    end

    // ----------------------------------------
    // wakeup flag
    // ----------------------------------------
    always_comb begin
        next_break_wakeup_flag = break_wakeup_flag;
        if (wr_en && hit(PADDR, brk_pkg::ADDR_WAKEUP_STATUS)
            && !PWDATA[brk_pkg::BREAK_WAKEUP_POS]) begin
            next_break_wakeup_flag = 1'b0;
        end
        if (trigger && sleeping) begin
            next_break_wakeup_flag = 1'b1;
        end
    end

    // ----------------------------------------
    // break sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            brk_pkg::ST_IDLE: begin
                if (trigger) begin
                    next_state = CPU_STATUS.break_start ? brk_pkg::ST_BREAK : brk_pkg::ST_PENDING;
                end
            end
            brk_pkg::ST_PENDING: begin
                if (CPU_STATUS.break_start) begin
                    next_state = brk_pkg::ST_BREAK;
                end
            end
            brk_pkg::ST_BREAK: begin
                if (CPU_STATUS.break_return) begin
                    next_state = brk_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = brk_pkg::ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // outputs toward cpu
    // ----------------------------------------
    always_comb begin
        next_control.break_request      = (next_state == brk_pkg::ST_PENDING);
        next_control.wake_request       = (next_state == brk_pkg::ST_PENDING) && sleeping;
        next_control.break_state        = (next_state == brk_pkg::ST_BREAK);
        next_control.timers_halt        = (next_state == brk_pkg::ST_BREAK);
        next_control.watchdog_off       = (next_state == brk_pkg::ST_BREAK) && tv_sync;
        next_control.flag_clear_allowed = (next_state != brk_pkg::ST_BREAK)
                                          || next_break_clear_enable_bit;
    end

    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    always_comb begin
        next_tv_meta = TEST_VOLTAGE_PIN;
        next_tv_sync = tv_meta;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            tv_meta <= 1'b0;
            tv_sync <= 1'b0;
        end else begin
            tv_meta <= next_tv_meta;
            tv_sync <= next_tv_sync;
        end
    end

    // ----------------------------------------
    // register file storage
    // ----------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            break_enable_bit       <= 1'b0;
            break_active_bit       <= 1'b0;
            break_clear_enable_bit <= 1'b0;
            break_address_high     <= brk_pkg::RESET_BYTE;
            break_address_low      <= brk_pkg::RESET_BYTE;
        end else begin
            break_enable_bit       <= next_break_enable_bit;
            break_active_bit       <= next_break_active_bit;
            break_clear_enable_bit <= next_break_clear_enable_bit;
            break_address_high     <= next_break_address_high;
            break_address_low      <= next_break_address_low;
        end
    end

    // ----------------------------------------
    // wakeup flag storage
    // ----------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            break_wakeup_flag <= 1'b0;
        end else begin
            break_wakeup_flag <= next_break_wakeup_flag;
        end
    end

    // ----------------------------------------
    // bus answer storage
    // ----------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PRDATA  <= next_prdata;
            PREADY  <= next_pready;
            PSLVERR <= next_pslverr;
        end
    end

    // ----------------------------------------
    // sequencer storage
    // ----------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            state <= brk_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // control storage
    // ----------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            CPU_CONTROL <= '{default: 1'b0, flag_clear_allowed: 1'b1};
        end else begin
            CPU_CONTROL <= next_control;
        end
    end

endmodule

// *** bench/cpu_model.sv ***
`timescale 1ns/10ps
module cpu_model (
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire brk_pkg::cpu_control_t ctrl,
    input  wire logic [15:0]           fetch_addr,
    input  wire logic                  fetch_valid,
    input  wire logic [2:0]            delay,
    input  wire logic                  ret_req,
    input  wire logic [1:0]            sleep,
    output brk_pkg::cpu_status_t       stat
);
    logic [2:0] cnt;
    logic       start;
    logic [1:0] mode;
    // break entry after a chosen number of cycles, low power held until woken
    always_ff @(posedge core_clk) begin
        cnt   <= (reset_n && ctrl.break_request) ? cnt + 3'h1 : 3'h0;
        start <= reset_n && ctrl.break_request && !start && cnt >= delay;
        mode  <= reset_n ? (sleep | (ctrl.wake_request ? 2'h0 : mode)) : 2'h0;
    end
    // released address bus shows the inverse
    assign stat = '{fetch_valid ? fetch_addr : ~fetch_addr, fetch_valid, fetch_valid, start,
                    ret_req && ctrl.break_state, mode[0], mode[1]};
endmodule

// *** bench/address_breakpoint_unit_chk.sv ***
`timescale 1ns/10ps
module address_breakpoint_unit_chk (
    input wire logic                  CORE_CLK,
    input wire logic                  RESET_N,
    input wire logic [7:0]            PADDR,
    input wire logic                  PSEL,
    input wire logic                  PENABLE,
    input wire logic                  PWRITE,
    input wire logic [31:0]           PWDATA,
    input wire logic                  PREADY,
    input wire brk_pkg::cpu_status_t  CPU_STATUS,
    input wire logic                  TEST_VOLTAGE_PIN,
    input wire brk_pkg::cpu_control_t CPU_CONTROL
);
    wire req   = CPU_CONTROL.break_request;
    wire start = CPU_STATUS.break_start;
    wire state = CPU_CONTROL.break_state;
    wire sw    = PSEL && PENABLE && PREADY && PWRITE && PADDR == brk_pkg::ADDR_STATUS_CONTROL
                 && PWDATA[brk_pkg::BREAK_ACTIVE_POS];
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    sw_break_a: assert property (sw && !req && !state |=> req || state)
        else $error("soft break missing");
    req_hold_a: assert property (req && !start |=> req)
        else $error("request dropped");
    take_break_a: assert property (req && start |=> !req && state)
        else $error("break not entered");
    ret_end_a: assert property (state && CPU_STATUS.break_return |=> !state)
        else $error("break kept");
    timer_halt_a: assert property (CPU_CONTROL.timers_halt == state)
        else $error("timer halt wrong");
    break_entry_a: assert property ($rose(CPU_CONTROL.timers_halt) |-> $past(start))
        else $error("timers halted without break start");
    watchdog_gate_a: assert property (CPU_CONTROL.watchdog_off |-> state)
        else $error("watchdog off outside break");
    watchdog_pin_a: assert property ((!TEST_VOLTAGE_PIN) [*4] |-> !CPU_CONTROL.watchdog_off)
        else $error("watchdog off without pin");
    clear_open_a: assert property (!state && !$past(state) |-> CPU_CONTROL.flag_clear_allowed)
        else $error("clear blocked");
    cover property (req && start);
    cover property (sw);
    cover property (CPU_CONTROL.wake_request);
endmodule
bind address_breakpoint_unit address_breakpoint_unit_chk chk (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PWDATA(PWDATA), .PREADY(PREADY), .CPU_STATUS(CPU_STATUS),
    .TEST_VOLTAGE_PIN(TEST_VOLTAGE_PIN), .CPU_CONTROL(CPU_CONTROL));

// *** bench/address_breakpoint_unit_tb.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, a, e); end end
module address_breakpoint_unit_tb;
    logic                  core_clk = 1'b0;
    logic                  reset_n, psel, penable, pwrite, test_pin, fetch_valid, ret_req;
    logic                  pready, pslverr, err;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic [2:0]            delay;
    logic [1:0]            sleep;
    brk_pkg::cpu_status_t  stat;
    brk_pkg::cpu_control_t ctrl;
    int                    failures = 0;
    int                    compares = 0;
    initial forever #4 core_clk = ~core_clk;
    address_breakpoint_unit dut (.CORE_CLK(core_clk), .RESET_N(reset_n), .PADDR(paddr),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CPU_STATUS(stat), .TEST_VOLTAGE_PIN(test_pin),
        .CPU_CONTROL(ctrl));
    cpu_model cpu (.core_clk(core_clk), .reset_n(reset_n), .ctrl(ctrl), .fetch_addr(16'h1234),
        .fetch_valid(fetch_valid), .delay(delay), .ret_req(ret_req), .sleep(sleep), .stat(stat));
    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bail(input bit ok);
        if (!ok) begin
            failures++;
            $display("[ERR] %0t wait ran out", $time);
            final_report;
        end
    endtask
    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        bit done = 0;
        @(posedge core_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk) penable <= 1'b1;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) {done, err, rd} = {1'b1, pslverr, prdata};
        end
        {psel, penable} <= 2'b00;
        bail(done);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic wait_state(input logic v);
        bit done = 0;
        for (int i = 0; i < 40 && !done; i++) @(posedge core_clk) done = ctrl.break_state === v;
        bail(done);
    endtask
    task automatic leave;
        @(posedge core_clk) ret_req <= 1'b1;
        @(posedge core_clk) ret_req <= 1'b0;
        wait_state(1'b0);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 5; i++) rd_chk(8'(i * 4), 32'h0);
        rd_chk(8'h14, 32'h0);
        `CHK(err, 1'b1)
        $display("reset test end");
    endtask
    task automatic t_match(input logic [2:0] dl);
        delay <= dl;
        apb(1'b1, 8'h04, 32'h12);
        apb(1'b1, 8'h08, 32'h34);
        rd_chk(8'h04, 32'h12);
        fetch_valid <= 1'b1;
        repeat (4) @(negedge core_clk);
        `CHK(ctrl.break_request, 1'b0)
        apb(1'b1, 8'h00, 32'h80);
        wait_state(1'b1);
        fetch_valid <= 1'b0;
        rd_chk(8'h00, 32'hC0);
        apb(1'b1, 8'h00, 32'h80);
        rd_chk(8'h00, 32'h80);
        leave;
        apb(1'b1, 8'h00, 32'h0);
        $display("match test end");
    endtask
    task automatic t_soft;
        test_pin <= 1'b1;
        apb(1'b1, 8'h00, 32'h40);
        wait_state(1'b1);
        @(negedge core_clk) `CHK({ctrl.timers_halt, ctrl.watchdog_off, ctrl.flag_clear_allowed}, 3'h6)
        apb(1'b1, 8'h10, 32'h80);
        @(negedge core_clk) `CHK(ctrl.flag_clear_allowed, 1'b1)
        @(posedge core_clk) test_pin <= 1'b0;
        repeat (4) @(negedge core_clk);
        `CHK({ctrl.break_state, ctrl.watchdog_off}, 2'h2)
        apb(1'b1, 8'h00, 32'h0);
        leave;
        $display("soft break test end");
    endtask
    task automatic t_sleep(input logic [1:0] s);
        @(posedge core_clk) sleep <= s;
        @(posedge core_clk) sleep <= 2'h0;
        apb(1'b1, 8'h00, 32'h80);
        fetch_valid <= 1'b1;
        wait_state(1'b1);
        fetch_valid <= 1'b0;
        `CHK(stat.in_wait | stat.in_stop, 1'b0)
        rd_chk(8'h0C, 32'h1 << brk_pkg::BREAK_WAKEUP_POS);
        apb(1'b1, 8'h0C, 32'h0);
        rd_chk(8'h0C, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        leave;
        $display("sleep test end");
    endtask
    task automatic t_rerst;
        apb(1'b1, 8'h04, 32'hAB);
        apb(1'b1, 8'h00, 32'hC0);
        wait_state(1'b1);
        @(posedge core_clk) reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk) `CHK(ctrl, 6'h01)
        t_reset;
        $display("second reset test end");
    endtask
    initial begin
        {reset_n, psel, penable, pwrite, test_pin, fetch_valid, ret_req} = 7'h00;
        {paddr, pwdata, delay, sleep} = 45'h0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset;
        t_match(3'h0);
        t_match(3'h5);
        t_soft;
        t_sleep(2'h1);
        t_sleep(2'h2);
        t_rerst;
        final_report;
    end
endmodule
